// [src/cad_pkg.sv]
// constants and types shared by the combined activity decision block
package cad_pkg;

	// widths
	localparam int SNR_W = 16;
	localparam int CNT_W = 8;
	localparam int TALLY_W = 10;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;

	// input sampling rate selection
	typedef enum logic [1:0] {
		RATE_OTHER = 2'b00,
		RATE_16K = 2'b01,
		RATE_32K = 2'b10
	} cad_rate_t;

	// snr thresholds, all snr values in units of 0.1
	localparam logic signed [SNR_W-1:0] FREQ_SNR_TH = 16'sh0002;
	localparam logic signed [SNR_W-1:0] HI_SMOOTH_TH = 16'sh0069;
	localparam logic signed [SNR_W-1:0] HI_FLUX_TH = 16'sh0016;
	localparam logic signed [SNR_W-1:0] MID_FLUX_TH = 16'sh000f;
	localparam logic signed [SNR_W-1:0] LO_SMOOTH_TH = 16'sh007d;
	localparam logic signed [SNR_W-1:0] LO_FLUX_TH = 16'sh0014;

	// frame count thresholds
	localparam logic [CNT_W-1:0] HI_CONT_TH = 8'h28;
	localparam logic [CNT_W-1:0] LO_CONT_TH = 8'h1e;
	localparam logic [CNT_W-1:0] CONT_MAX = 8'hff;
	localparam logic [TALLY_W-1:0] TALLY_MAX = 10'h3e8;
	localparam logic [TALLY_W-1:0] TALLY_FORCE_LIM = 10'h00c;
	localparam logic [CNT_W-1:0] BUDGET_MIN = 8'h14;

	// snr flux averaging window
	localparam int AVG_LEN = 8;
	localparam int AVG_SH = 3;
	localparam int PTR_W = 3;

	// register indices on the plain register port
	localparam logic [ADDR_W-1:0] IDX_CFG = 4'h0;
	localparam logic [ADDR_W-1:0] IDX_RAW_TH = 4'h1;
	localparam logic [ADDR_W-1:0] IDX_SMOOTH_TH = 4'h2;
	localparam logic [ADDR_W-1:0] IDX_STATUS = 4'h3;
	localparam logic [ADDR_W-1:0] IDX_TALLY = 4'h4;
	localparam logic [ADDR_W-1:0] IDX_BUDGET = 4'h5;
	localparam logic [ADDR_W-1:0] IDX_COUNT = 4'h6;
	localparam logic [ADDR_W-1:0] IDX_FLUX = 4'h7;

	// reset values
	localparam logic [1:0] CFG_RST = 2'h1;
	localparam logic signed [SNR_W-1:0] RAW_TH_RST = 16'sh0028;
	localparam logic signed [SNR_W-1:0] SMOOTH_TH_RST = 16'sh0050;

endpackage : cad_pkg

// [src/cad_snr_avg.sv]
// background noise energy tracking and averaged sub-band snr
`timescale 1ns/1ps
`default_nettype none

module cad_snr_avg (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// frame inputs
	input wire logic frame_stb,
	input wire logic bg_update,
	input wire logic tonal,
	input wire logic signed [15:0] frame_energy,
	// current frame averaged snr
	output logic signed [15:0] flux_now
);

	logic prev_bg_q, prev_bg_d;
	logic prev_tonal_q, prev_tonal_d;
	logic signed [15:0] prev_energy_q, prev_energy_d;
	logic signed [15:0] bg1_q, bg1_d;
	logic signed [15:0] bg2_q, bg2_d;
	logic signed [15:0] hist_q [cad_pkg::AVG_LEN];
	logic signed [15:0] hist_d [cad_pkg::AVG_LEN];
	logic [cad_pkg::PTR_W-1:0] ptr_q, ptr_d;
	logic signed [18:0] sum_q, sum_d;
	logic signed [17:0] mix;
	logic signed [16:0] diff;
	logic signed [15:0] bg_prev;
	logic signed [15:0] inst;
	logic signed [18:0] sum_new;

	always_comb
	begin
		// previous frame background from its own flags and two older frames
		mix = 18'(prev_energy_q) + 18'(prev_energy_q) + 18'(bg1_q) + 18'(bg2_q);
		bg_prev = (prev_bg_q && !prev_tonal_q) ? 16'(mix >>> 2) : bg1_q;
		diff = 17'(frame_energy) - 17'(bg_prev);
		inst = diff[15:0];
		sum_new = sum_q - 19'(hist_q[ptr_q]) + 19'(inst);
		flux_now = 16'(sum_new >>> cad_pkg::AVG_SH);
		prev_bg_d = prev_bg_q;
		prev_tonal_d = prev_tonal_q;
		prev_energy_d = prev_energy_q;
		bg1_d = bg1_q;
		bg2_d = bg2_q;
		hist_d = hist_q;
		ptr_d = ptr_q;
		sum_d = sum_q;
		if (frame_stb)
		begin
			prev_bg_d = bg_update;
			prev_tonal_d = tonal;
			prev_energy_d = frame_energy;
			bg1_d = bg_prev;
			bg2_d = bg1_q;
			hist_d[ptr_q] = inst;
			ptr_d = ptr_q + 3'h1;
			sum_d = sum_new;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			prev_bg_q <= 1'h0;
			prev_tonal_q <= 1'h0;
			prev_energy_q <= 16'sh0000;
			bg1_q <= 16'sh0000;
			bg2_q <= 16'sh0000;
			for (int i = 0; i < cad_pkg::AVG_LEN; i++)
				hist_q[i] <= 16'sh0000;
			ptr_q <= 3'h0;
			sum_q <= 19'sh00000;
		end
		else
		begin
			prev_bg_q <= prev_bg_d;
			prev_tonal_q <= prev_tonal_d;
			prev_energy_q <= prev_energy_d;
			bg1_q <= bg1_d;
			bg2_q <= bg2_d;
			hist_q <= hist_d;
			ptr_q <= ptr_d;
			sum_q <= sum_d;
		end
	end

endmodule : cad_snr_avg

`default_nettype wire

// [src/cad_top.sv]
// combined activity decision with forced-active extension
`timescale 1ns/1ps
`default_nettype none

//Behaviour
// - noise type defaults non-silence; silence when both long-term snrs exceed thresholds
// - at 16/32 kHz merged decision starts from the third detector flag
// - at 16/32 kHz silence, freq snr over 0.2, merged zero: take first flag
// - at 16/32 kHz smooth snr under 10.5 or non-silence checks or terms
// - at 16/32 kHz or of both flags when flux or count or tonal qualify
// - no or term: 32 kHz first flag if silence else third; 16 kHz first
// - other rates start from third flag, branch on silence or non-silence
// - other rates silence: first flag if smooth snr over 12.5 and not tonal
// - other rates non-silence: or of flags when flux, count or tonal qualify
// - background frames raise the noise-update tally, saturating at 1000
// - noise-update tally clears at codec initialisation
// - third flag active and tally below 12 loads budget with max(20, hangover)
// - inactive merged decision with budget above zero forced active, budget decrements
// - previous frame background energy from its flags and two older frames
// - averaged sub-band snr from previous background and current energy
// - consecutive active count zero first frame, then follows previous decision
// - hangover length arrives from outside each frame
module cad_top (
	// clock and reset
	input wire logic REF_CLK,
	input wire logic RST,
	// frame features
	input wire logic FRAME_STB,
	input wire logic FIRST_ACT,
	input wire logic THIRD_ACT,
	input wire logic TONAL,
	input wire logic BG_UPDATE,
	input wire logic signed [15:0] RAW_LT_SNR,
	input wire logic signed [15:0] SMOOTH_LT_SNR,
	input wire logic signed [15:0] FREQ_SNR,
	input wire logic signed [15:0] FRAME_ENERGY,
	input wire logic [7:0] HANG_LEN,
	// register port
	input wire logic [3:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic REG_WE,
	input wire logic REG_RE,
	output logic [31:0] REG_RDATA,
	// decision
	output logic MERGED_ACT,
	output logic DECISION_VALID,
	output logic NOISE_SILENT
);

	// configuration registers
	logic [1:0] cfg_q, cfg_d;
	logic signed [15:0] raw_th_q, raw_th_d;
	logic signed [15:0] smooth_th_q, smooth_th_d;
	logic [31:0] rdata_q, rdata_d;

	// frame state
	logic [9:0] tally_q, tally_d;
	logic [7:0] budget_q, budget_d;
	logic [7:0] cont_q, cont_d;
	logic merged_q, merged_d;
	logic silent_q, silent_d;
	logic first_q, first_d;
	logic valid_q, valid_d;
	logic signed [15:0] flux_q, flux_d;

	// per-frame decision terms
	cad_pkg::cad_rate_t rate;
	logic signed [15:0] flux_now;
	logic silent_now;
	logic [7:0] cont_now;
	logic merged_now;
	logic [9:0] tally_now;
	logic [7:0] budget_ld;
	logic [7:0] budget_new;
	logic final_now;

	function automatic logic [7:0] cad_max8(input logic [7:0] a, input logic [7:0] b);
		cad_max8 = (a > b) ? a : b;
	endfunction : cad_max8

	function automatic logic cad_merge(
		input cad_pkg::cad_rate_t sel,
		input logic silent,
		input logic first,
		input logic third,
		input logic tonal,
		input logic signed [15:0] freq,
		input logic signed [15:0] smooth,
		input logic signed [15:0] flux,
		input logic [7:0] cont
	);
		logic res;
		logic or_hi;
		logic or_lo;
		logic lo_res;
		res = third;
		or_hi = (flux > cad_pkg::HI_FLUX_TH) || tonal
			|| ((flux > cad_pkg::MID_FLUX_TH) && (cont > cad_pkg::HI_CONT_TH));
		or_lo = (flux > cad_pkg::LO_FLUX_TH) || tonal
			|| ((flux > cad_pkg::MID_FLUX_TH) && (cont > cad_pkg::LO_CONT_TH));
		lo_res = third;
		if (silent)
		begin
			if ((smooth > cad_pkg::LO_SMOOTH_TH) && !tonal)
				lo_res = first;
		end
		else if (or_lo)
			lo_res = first | third;
		unique case (sel)
			cad_pkg::RATE_16K, cad_pkg::RATE_32K:
			begin
				if (silent && (freq > cad_pkg::FREQ_SNR_TH) && !third)
					res = first;
				else if ((smooth < cad_pkg::HI_SMOOTH_TH) || !silent)
				begin
					if (or_hi)
						res = first | third;
					else if (sel == cad_pkg::RATE_16K)
						res = first;
					else if (silent)
						res = first;
				end
			end
			cad_pkg::RATE_OTHER:
				res = lo_res;
			default:
				res = lo_res;
		endcase
		cad_merge = res;
	endfunction : cad_merge

	cad_snr_avg u_snr_avg (
		.clk(REF_CLK),
		.rst(RST),
		.frame_stb(FRAME_STB),
		.bg_update(BG_UPDATE),
		.tonal(TONAL),
		.frame_energy(FRAME_ENERGY),
		.flux_now(flux_now)
	);

	// combined decision for the frame on the inputs
	always_comb
	begin
		rate = cad_pkg::cad_rate_t'(cfg_q);
		silent_now = (RAW_LT_SNR > raw_th_q) && (SMOOTH_LT_SNR > smooth_th_q);
		if (first_q)
			cont_now = 8'h00;
		else if (merged_q)
			cont_now = (cont_q == cad_pkg::CONT_MAX) ? cont_q : cont_q + 8'h01;
		else
			cont_now = 8'h00;
		merged_now = cad_merge(rate, silent_now, FIRST_ACT, THIRD_ACT, TONAL,
			FREQ_SNR, SMOOTH_LT_SNR, flux_now, cont_now);
		if (BG_UPDATE && (tally_q < cad_pkg::TALLY_MAX))
			tally_now = tally_q + 10'h001;
		else
			tally_now = tally_q;
		if (THIRD_ACT && (tally_now < cad_pkg::TALLY_FORCE_LIM))
			budget_ld = cad_max8(cad_pkg::BUDGET_MIN, HANG_LEN);
		else
			budget_ld = budget_q;
		if (!merged_now && (budget_ld != 8'h00))
		begin
			final_now = 1'h1;
			budget_new = budget_ld - 8'h01;
		end
		else
		begin
			final_now = merged_now;
			budget_new = budget_ld;
		end
	end

	// frame state updates once per strobe
	always_comb
	begin
		tally_d = tally_q;
		budget_d = budget_q;
		cont_d = cont_q;
		merged_d = merged_q;
		silent_d = silent_q;
		first_d = first_q;
		flux_d = flux_q;
		valid_d = 1'h0;
		if (FRAME_STB)
		begin
			tally_d = tally_now;
			budget_d = budget_new;
			cont_d = cont_now;
			merged_d = final_now;
			silent_d = silent_now;
			first_d = 1'h0;
			flux_d = flux_now;
			valid_d = 1'h1;
		end
	end

	always_ff @(posedge REF_CLK)
	begin
		if (RST)
		begin
			tally_q <= 10'h000;
			budget_q <= 8'h00;
			cont_q <= 8'h00;
			merged_q <= 1'h0;
			silent_q <= 1'h0;
			first_q <= 1'h1;
			flux_q <= 16'sh0000;
			valid_q <= 1'h0;
		end
		else
		begin
			tally_q <= tally_d;
			budget_q <= budget_d;
			cont_q <= cont_d;
			merged_q <= merged_d;
			silent_q <= silent_d;
			first_q <= first_d;
			flux_q <= flux_d;
			valid_q <= valid_d;
		end
	end

	// register writes and reads
	always_comb
	begin
		cfg_d = cfg_q;
		raw_th_d = raw_th_q;
		smooth_th_d = smooth_th_q;
		rdata_d = 32'h00000000;
		if (REG_WE)
		begin
			unique case (REG_ADDR)
				cad_pkg::IDX_CFG: cfg_d = REG_WDATA[1:0];
				cad_pkg::IDX_RAW_TH: raw_th_d = REG_WDATA[15:0];
				cad_pkg::IDX_SMOOTH_TH: smooth_th_d = REG_WDATA[15:0];
				default: cfg_d = cfg_q;
			endcase
		end
		if (REG_RE)
		begin
			unique case (REG_ADDR)
				cad_pkg::IDX_CFG: rdata_d = {30'h00000000, cfg_q};
				cad_pkg::IDX_RAW_TH: rdata_d = {16'h0000, raw_th_q};
				cad_pkg::IDX_SMOOTH_TH: rdata_d = {16'h0000, smooth_th_q};
				cad_pkg::IDX_STATUS: rdata_d = {29'h00000000, first_q, silent_q, merged_q};
				cad_pkg::IDX_TALLY: rdata_d = {22'h000000, tally_q};
				cad_pkg::IDX_BUDGET: rdata_d = {24'h000000, budget_q};
				cad_pkg::IDX_COUNT: rdata_d = {24'h000000, cont_q};
				cad_pkg::IDX_FLUX: rdata_d = {16'h0000, flux_q};
				default: rdata_d = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge REF_CLK)
	begin
		if (RST)
		begin
			cfg_q <= cad_pkg::CFG_RST;
			raw_th_q <= cad_pkg::RAW_TH_RST;
			smooth_th_q <= cad_pkg::SMOOTH_TH_RST;
			rdata_q <= 32'h00000000;
		end
		else
		begin
			cfg_q <= cfg_d;
			raw_th_q <= raw_th_d;
			smooth_th_q <= smooth_th_d;
			rdata_q <= rdata_d;
		end
	end

	assign REG_RDATA = rdata_q;
	assign MERGED_ACT = merged_q;
	assign DECISION_VALID = valid_q;
	assign NOISE_SILENT = silent_q;

	// checks
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (RST);

	tally_step_a: assert property (
		FRAME_STB && BG_UPDATE && (tally_q < cad_pkg::TALLY_MAX)
		|=> tally_q == $past(tally_q) + 10'h001)
		else $error("tally did not step on background frame");

	tally_sat_a: assert property (
		(tally_q == cad_pkg::TALLY_MAX) |=> (tally_q == cad_pkg::TALLY_MAX))
		else $error("tally left saturation");

	tally_init_a: assert property (
		disable iff (1'h0) RST |=> (tally_q == 10'h000))
		else $error("tally not cleared at reset");

	reset_clear_a: assert property (
		disable iff (1'h0) RST |=> (budget_q == 8'h00) && !NOISE_SILENT)
		else $error("budget or noise type not cleared at reset");

	silence_flag_a: assert property (
		FRAME_STB && ((RAW_LT_SNR <= raw_th_q) || (SMOOTH_LT_SNR <= smooth_th_q))
		|=> !NOISE_SILENT)
		else $error("silence flagged without both snrs high");

	budget_load_a: assert property (
		FRAME_STB && THIRD_ACT && (tally_now < cad_pkg::TALLY_FORCE_LIM)
		|=> budget_q >= cad_max8(cad_pkg::BUDGET_MIN, $past(HANG_LEN)) - 8'h01)
		else $error("budget not loaded");

	force_act_a: assert property (
		FRAME_STB && !merged_now && (budget_ld != 8'h00)
		|=> MERGED_ACT && (budget_q == $past(budget_ld) - 8'h01))
		else $error("forced activity or decrement missing");

	or_hi_a: assert property (
		FRAME_STB && (rate != cad_pkg::RATE_OTHER) && !silent_now && TONAL
		&& (FIRST_ACT || THIRD_ACT) |=> MERGED_ACT)
		else $error("or of flags missing at high rate");

	lo_silence_a: assert property (
		FRAME_STB && (rate == cad_pkg::RATE_OTHER) && silent_now && TONAL
		&& THIRD_ACT |=> MERGED_ACT)
		else $error("third flag lost in silence branch");

	cont_clear_a: assert property (
		FRAME_STB && !merged_q |=> (cont_q == 8'h00))
		else $error("active count not cleared");

	one_eval_a: assert property (
		!FRAME_STB |=> !DECISION_VALID && $stable(tally_q) && $stable(budget_q))
		else $error("state changed without strobe");

	forced_c: cover property (FRAME_STB && !merged_now && (budget_ld != 8'h00));
	hi_or_c: cover property (FRAME_STB && (rate == cad_pkg::RATE_32K) && silent_now);
	lo_rate_c: cover property (FRAME_STB && (rate == cad_pkg::RATE_OTHER) && !silent_now);
	tally_full_c: cover property (tally_q == cad_pkg::TALLY_MAX);

endmodule : cad_top

`default_nettype wire

// [test/cad_feed.sv]
// upstream frame feature source model
`timescale 1ns/1ps
`default_nettype none
module cad_feed (
	// clock
	input wire logic clk,
	// request from the bench
	input wire logic go,
	input wire logic [75:0] v_in,
	// frame strobe and features
	output logic stb,
	output logic [75:0] v
);
	logic [75:0] last_q;
	initial stb = 1'b0;
	initial v = '0;
	initial last_q = '0;
	// one-cycle strobe; features garbled outside it
	always @(posedge clk)
	begin
		stb <= go;
		if (go)
			last_q <= v_in;
		v <= go ? v_in : ~last_q;
	end
endmodule : cad_feed
`default_nettype wire

// [test/cad_top_test.sv]
// self-checking bench of the combined activity decision
`timescale 1ns/1ps
`default_nettype none
module cad_top_test;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic go = 1'b0;
	logic [75:0] v_in = '0;
	logic stb;
	logic [75:0] fv;
	logic [3:0] addr = '0;
	logic [31:0] wdata = '0;
	logic we = 1'b0;
	logic re = 1'b0;
	logic [31:0] rdata;
	logic merged, valid, silent;
	int num_errors = 0, comparisons = 0, cycles = 0;
	int tally, budget, cont, bg1, bg2, pe, raw_th, sm_th, rate, flux;
	int hist[8];
	bit pm, fp, pbg, pton;
	logic [1:0] exp_q[$];
	logic [31:0] d;

	initial
	begin
		forever #5 clk = ~clk;
	end

	cad_feed feed (.clk(clk), .go(go), .v_in(v_in), .stb(stb), .v(fv));
	cad_top dut (.REF_CLK(clk), .RST(rst), .FRAME_STB(stb),
		.FIRST_ACT(fv[0]), .THIRD_ACT(fv[1]), .TONAL(fv[2]),
		.BG_UPDATE(fv[3]), .RAW_LT_SNR(fv[19:4]),
		.SMOOTH_LT_SNR(fv[35:20]), .FREQ_SNR(fv[51:36]),
		.FRAME_ENERGY(fv[67:52]), .HANG_LEN(fv[75:68]),
		.REG_ADDR(addr), .REG_WDATA(wdata), .REG_WE(we), .REG_RE(re),
		.REG_RDATA(rdata), .MERGED_ACT(merged), .DECISION_VALID(valid),
		.NOISE_SILENT(silent));

	task automatic check_bit(input logic got, input logic exp, input string s);
		comparisons++;
		if (got !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED at %0t: %s got %b", $time, s, got);
		end
	endtask : check_bit

	task automatic check_word(input logic [31:0] got, input logic [31:0] exp,
		input string s);
		comparisons++;
		if (got !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, s, got, exp);
		end
	endtask : check_word

	task automatic wr(input logic [3:0] a, input logic [31:0] w);
		@(posedge clk);
		we <= 1'b1;
		addr <= a;
		wdata <= w;
		@(posedge clk);
		we <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, output logic [31:0] r);
		@(posedge clk);
		re <= 1'b1;
		addr <= a;
		@(posedge clk);
		re <= 1'b0;
		#1;
		r = rdata;
	endtask : rd

	function automatic bit decide(int r, bit sil, bit f, bit t, bit ton,
		int fq, int sm, int fl, int c);
		bit orc;
		if (r == 1 || r == 2)
		begin
			orc = fl > cad_pkg::HI_FLUX_TH || ton
				|| (fl > cad_pkg::MID_FLUX_TH && c > cad_pkg::HI_CONT_TH);
			if (sil && fq > cad_pkg::FREQ_SNR_TH && !t)
				return f;
			if (sm < cad_pkg::HI_SMOOTH_TH || !sil)
				return orc ? (f | t) : (r == 2 ? (sil ? f : t) : f);
			return t;
		end
		orc = fl > cad_pkg::LO_FLUX_TH || ton
			|| (fl > cad_pkg::MID_FLUX_TH && c > cad_pkg::LO_CONT_TH);
		if (sil)
			return (sm > cad_pkg::LO_SMOOTH_TH && !ton) ? f : t;
		return orc ? (f | t) : t;
	endfunction : decide

	task automatic model(input logic [75:0] f);
		int bgn, s, e;
		bit sil, m;
		e = int'($signed(f[67:52]));
		bgn = (pbg && !pton) ? (2 * pe + bg1 + bg2) >>> 2 : bg1;
		s = 0;
		for (int i = 7; i > 0; i--)
			hist[i] = hist[i-1];
		hist[0] = e - bgn;
		foreach (hist[i])
			s += hist[i];
		flux = s >>> 3;
		cont = fp ? 0 : (pm ? (cont == 255 ? 255 : cont + 1) : 0);
		sil = $signed(f[19:4]) > raw_th && $signed(f[35:20]) > sm_th;
		m = decide(rate, sil, f[0], f[1], f[2], $signed(f[51:36]),
			$signed(f[35:20]), s >>> 3, cont);
		if (f[3] && tally < 1000)
			tally++;
		if (f[1] && tally < 12)
			budget = f[75:68] > 20 ? f[75:68] : 20;
		if (!m && budget > 0)
		begin
			m = 1;
			budget--;
		end
		{fp, pm, pbg, pton, pe, bg2, bg1} = {1'b0, m, f[3], f[2], e, bg1, bgn};
		exp_q.push_back({sil, m});
	endtask : model

	task automatic reset_all();
		@(posedge clk);
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		{tally, budget, cont, bg1, bg2, pe} = '0;
		rate = 1;
		{pm, fp, pbg, pton} = 4'b0100;
		hist = '{default: 0};
		raw_th = 40;
		sm_th = 80;
	endtask : reset_all

	task automatic frames(input int n, input bit all_bg);
		logic [75:0] f;
		for (int i = 0; i < n; i++)
		begin
			@(posedge clk);
			f = {8'($urandom % 41), 16'($urandom % 128), 16'($urandom % 5),
				16'(60 + $urandom % 100), 16'($urandom % 80),
				1'($urandom) | all_bg, 1'($urandom % 4 == 0), 2'($urandom)};
			go <= 1'b1;
			v_in <= f;
			model(f);
		end
		@(posedge clk);
		go <= 1'b0;
		for (int k = 0; k < 20 && exp_q.size() != 0; k++)
			@(posedge clk);
		check_word(exp_q.size(), 0, "missing decisions");
	endtask : frames

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 10000)
		begin
			num_errors++;
			wrap_up();
		end
		else if (valid === 1'b1)
		begin
			check_word(exp_q.size() != 0, 1, "extra decision");
			if (exp_q.size() != 0)
			begin
				check_bit(merged, exp_q[0][0], "merged");
				check_bit(silent, exp_q[0][1], "silent");
				void'(exp_q.pop_front());
			end
		end
	end

	task automatic wrap_up();
		$display("comparisons %0d num_errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : wrap_up

	initial
	begin
		void'($urandom(32'h1261));
		reset_all();
		rd(cad_pkg::IDX_CFG, d);
		check_word(d, 32'h1, "cfg reset");
		rd(cad_pkg::IDX_RAW_TH, d);
		check_word(d, 32'h28, "raw th reset");
		rd(cad_pkg::IDX_SMOOTH_TH, d);
		check_word(d, 32'h50, "smooth th reset");
		wr(cad_pkg::IDX_TALLY, 32'h55);
		rd(cad_pkg::IDX_TALLY, d);
		check_word(d, 32'h0, "tally ro");
		rd(4'hc, d);
		check_word(d, 32'h0, "unmapped");
		for (int r = 0; r < 4; r++)
		begin
			reset_all();
			rd(cad_pkg::IDX_BUDGET, d);
			check_word(d, 32'h0, "budget reset");
			rd(cad_pkg::IDX_STATUS, d);
			check_word(d[1:0], 2'h0, "status reset");
			rate = r;
			raw_th = 20 + $urandom % 40;
			wr(cad_pkg::IDX_CFG, r);
			wr(cad_pkg::IDX_RAW_TH, raw_th);
			sm_th = 70 + $urandom % 40;
			wr(cad_pkg::IDX_SMOOTH_TH, sm_th);
			frames(60, 1'b0);
			rd(cad_pkg::IDX_TALLY, d);
			check_word(d, tally, "tally");
			rd(cad_pkg::IDX_BUDGET, d);
			check_word(d, budget, "budget");
			rd(cad_pkg::IDX_COUNT, d);
			check_word(d, cont, "count");
			rd(cad_pkg::IDX_FLUX, d);
			check_word(d, {16'h0000, 16'(flux)}, "flux");
			$display("rate pass %0d done", r);
		end
		frames(1010, 1'b1);
		rd(cad_pkg::IDX_TALLY, d);
		check_word(d, tally, "tally saturated");
		$display("saturation test done");
		wrap_up();
	end
endmodule : cad_top_test
`default_nettype wire
